// ===== rtl/hsr_dup_table_pkg.sv
package hsr_dup_table_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int unsigned ADDR_WIDTH = 12;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned LANES = 4;
  localparam int unsigned LANE_WIDTH = 8;
  localparam int unsigned WORD_LSB = 2;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [31:0] WORD_FULL = 32'hFFFFFFFF;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] OFF_INDEX_HIGH = 12'h444;
  localparam logic [11:0] OFF_INDEX_LOW = 12'h448;
  localparam logic [11:0] OFF_ACCESS_CTRL = 12'h450;
  localparam logic [11:0] OFF_ENTRY_FLAGS = 12'h454;
  localparam logic [11:0] OFF_DEST_HIGH = 12'h458;
  localparam logic [11:0] OFF_DEST_LOW_SRC_HIGH = 12'h45C;
  localparam logic [11:0] OFF_SRC_LOW = 12'h460;
  localparam logic [11:0] OFF_START_SEQ = 12'h464;
  localparam logic [11:0] OFF_EXPECTED_SEQ = 12'h468;
  localparam logic [11:0] OFF_OUT_OF_ORDER = 12'h46C;

  // ****************************************
  // field layouts
  // ****************************************
  localparam int unsigned PERM_BIT = 31;
  localparam int unsigned AGE_MSB = 28;
  localparam int unsigned AGE_LSB = 26;
  localparam int unsigned PATH_MSB = 3;
  localparam int unsigned PATH_LSB = 0;
  localparam logic [31:0] FLAGS_WRITE_MASK = 32'h9C00000F;
  localparam logic [31:0] INDEX_HIGH_MASK = 32'h0000FFFF;
  localparam int unsigned HI_MSB = 31;
  localparam int unsigned HI_LSB = 16;
  localparam int unsigned LO_MSB = 15;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned ADDR_MSB = 47;
  localparam int unsigned DEST_SPLIT = 16;
  localparam int unsigned SRC_SPLIT = 32;
  localparam int unsigned DIRECT_MSB = 7;
  localparam int unsigned COUNT_MSB = 29;
  localparam int unsigned COUNT_LSB = 16;
  localparam int unsigned GO_BIT = 7;
  localparam int unsigned VALID_BIT = 6;
  localparam int unsigned READY_OR_OVER_BIT = 5;
  localparam int unsigned DIRECT_BIT = 2;
  localparam int unsigned ACTION_MSB = 1;
  localparam int unsigned ACTION_LSB = 0;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h3FFF00C7;

  // ****************************************
  // table and operations
  // ****************************************
  localparam int unsigned TABLE_DEPTH = 256;
  localparam int unsigned SLOT_WIDTH = 8;
  localparam int unsigned COUNT_WIDTH = 14;
  localparam int unsigned HASH_BYTES = 6;
  localparam logic [7:0] LAST_SLOT = 8'hFF;
  localparam logic [1:0] ACTION_NONE = 2'h0;
  localparam logic [1:0] ACTION_WRITE = 2'h1;
  localparam logic [1:0] ACTION_READ = 2'h2;
  localparam logic [1:0] ACTION_SEARCH = 2'h3;

  typedef enum logic [1:0] {IDLE, EXEC, SEARCH} state_type;

  typedef struct packed {
    logic permanent;
    logic [2:0] entryAge;
    logic [3:0] tagPath;
    logic [47:0] destStationAddr;
    logic [47:0] sourceStationAddr;
    logic [15:0] initialSeqnumPortA;
    logic [15:0] initialSeqnumPortB;
    logic [15:0] awaitedSeqnumPortA;
    logic [15:0] awaitedSeqnumPortB;
    logic [15:0] misorderedTotalPortA;
    logic [15:0] misorderedTotalPortB;
  } entry_type;

  localparam entry_type ENTRY_ZERO = '0;

endpackage

// ===== rtl/hsr_duplicate_table_data_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - flags bit 31 marks an entry permanent and hence valid.
// - flags hold age in 28:26, tag path in 3:0, rest reserved.
// - second value word holds destination address bits 47:16.
// - direct mode takes second value word bits 7:0 as table slot.
// - third word: destination low half 31:16, source high half 15:0.
// - fourth word holds source address bits 31:0.
// - fifth word: start sequence port A 31:16, port B 15:0.
// - sixth word: expected sequence port A 31:16, port B 15:0.
// - seventh word: out-of-order count port A 31:16, port B 15:0.
// - table keeps sequence data; a read loads the seven value words.
// - start and expected sequences are stored exactly as supplied.
// - action field: 00 none, 01 write, 10 read, 11 search.
// - software sets go bit 7; hardware clears it when done.
// - control bit 2 selects direct slot instead of hashed address.
// - search end reports valid entry total in control bits 29:16.
module hsr_duplicate_table_data_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [hsr_dup_table_pkg::ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [hsr_dup_table_pkg::DATA_WIDTH-1:0] avs_writedata,
  input wire logic [hsr_dup_table_pkg::LANES-1:0] avs_byteenable,
  output logic [hsr_dup_table_pkg::DATA_WIDTH-1:0] avs_readdata,
  output logic avs_waitrequest
);

  // ****************************************
  // declarations
  // ****************************************
  logic ackFf;
  logic [31:0] readDataFf;
  logic [31:0] laneMask;
  logic [31:0] readView;
  logic [31:0] flagsView;
  logic [31:0] destHighView;
  logic [31:0] destLowSrcHighView;
  logic [31:0] srcLowView;
  logic [31:0] startView;
  logic [31:0] expectedView;
  logic [31:0] outOfOrderView;
  logic [31:0] ctrlView;
  logic [31:0] ctrlNew;
  logic [15:0] indexHighFf;
  logic [31:0] indexHighNew;
  logic [31:0] indexLowFf;
  hsr_dup_table_pkg::entry_type valueFf;
  hsr_dup_table_pkg::entry_type nxt_value;
  hsr_dup_table_pkg::entry_type readEntry;
  hsr_dup_table_pkg::entry_type tableMem [hsr_dup_table_pkg::TABLE_DEPTH];
  logic [hsr_dup_table_pkg::TABLE_DEPTH-1:0] writtenFf;
  logic [hsr_dup_table_pkg::TABLE_DEPTH-1:0] permFf;
  logic goFf;
  logic validFf;
  logic searchOverFf;
  logic directFf;
  logic [1:0] actionFf;
  logic [13:0] validCountFf;
  hsr_dup_table_pkg::state_type stateFf;
  logic [1:0] opFf;
  logic [7:0] slotFf;
  logic [7:0] scanFf;
  logic [13:0] tallyFf;
  logic [13:0] tallyStep;
  logic [7:0] hashSlot;
  logic [7:0] directSlot;
  logic wrStrobe;
  logic start;
  logic searchEnd;

  // ****************************************
  // bus slave
  // ****************************************
  // every access gets exactly one wait cycle so read data can be registered
  assign avs_waitrequest = ~ackFf;
  assign avs_readdata = readDataFf;
  assign wrStrobe = avs_write & ackFf;

  function automatic logic isAt(input logic [11:0] addr,
                                input logic [11:0] off);
    isAt = addr[11:hsr_dup_table_pkg::WORD_LSB] ==
           off[11:hsr_dup_table_pkg::WORD_LSB];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] lanes,
                                        input logic [31:0] wdata,
                                        input logic [31:0] mask);
    merge = (old & ~(lanes & mask)) | (wdata & lanes & mask);
  endfunction

  genvar lane;
  generate
    for (lane = 0; lane < hsr_dup_table_pkg::LANES; lane++) begin : g_lane
      assign laneMask[lane*hsr_dup_table_pkg::LANE_WIDTH +:
                      hsr_dup_table_pkg::LANE_WIDTH] =
        {hsr_dup_table_pkg::LANE_WIDTH{avs_byteenable[lane]}};
    end
  endgenerate

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ackFf <= 1'b0;
    end else begin
      ackFf <= (avs_read | avs_write) & ~ackFf;
    end
  end

  // unmapped addresses read zero and take no write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readDataFf <= hsr_dup_table_pkg::WORD_ZERO;
    end else if (avs_read & ~ackFf) begin
      readDataFf <= readView;
    end
  end

  // ****************************************
  // register views
  // ****************************************
  always_comb begin
    flagsView = hsr_dup_table_pkg::WORD_ZERO;
    flagsView[hsr_dup_table_pkg::PERM_BIT] = valueFf.permanent;
    flagsView[hsr_dup_table_pkg::AGE_MSB:hsr_dup_table_pkg::AGE_LSB] =
      valueFf.entryAge;
    flagsView[hsr_dup_table_pkg::PATH_MSB:hsr_dup_table_pkg::PATH_LSB] =
      valueFf.tagPath;
    destHighView =
      valueFf.destStationAddr[hsr_dup_table_pkg::ADDR_MSB:
                              hsr_dup_table_pkg::DEST_SPLIT];
    destLowSrcHighView = {
      valueFf.destStationAddr[hsr_dup_table_pkg::DEST_SPLIT-1:0],
      valueFf.sourceStationAddr[hsr_dup_table_pkg::ADDR_MSB:
                                hsr_dup_table_pkg::SRC_SPLIT]};
    srcLowView =
      valueFf.sourceStationAddr[hsr_dup_table_pkg::SRC_SPLIT-1:0];
    startView = {valueFf.initialSeqnumPortA,
                 valueFf.initialSeqnumPortB};
    expectedView = {valueFf.awaitedSeqnumPortA,
                    valueFf.awaitedSeqnumPortB};
    outOfOrderView = {valueFf.misorderedTotalPortA,
                      valueFf.misorderedTotalPortB};
    ctrlView = hsr_dup_table_pkg::WORD_ZERO;
    ctrlView[hsr_dup_table_pkg::COUNT_MSB:hsr_dup_table_pkg::COUNT_LSB] =
      validCountFf;
    ctrlView[hsr_dup_table_pkg::GO_BIT] = goFf;
    ctrlView[hsr_dup_table_pkg::VALID_BIT] = validFf;
    ctrlView[hsr_dup_table_pkg::READY_OR_OVER_BIT] = validFf | searchOverFf;
    ctrlView[hsr_dup_table_pkg::DIRECT_BIT] = directFf;
    ctrlView[hsr_dup_table_pkg::ACTION_MSB:hsr_dup_table_pkg::ACTION_LSB] =
      actionFf;
  end

  always_comb begin
    readView = hsr_dup_table_pkg::WORD_ZERO;
    if (isAt(avs_address, hsr_dup_table_pkg::OFF_INDEX_HIGH)) begin
      readView[hsr_dup_table_pkg::LO_MSB:hsr_dup_table_pkg::LO_LSB] =
        indexHighFf;
    end
    if (isAt(avs_address, hsr_dup_table_pkg::OFF_INDEX_LOW)) begin
      readView = indexLowFf;
    end
    if (isAt(avs_address, hsr_dup_table_pkg::OFF_ACCESS_CTRL)) begin
      readView = ctrlView;
    end
    if (isAt(avs_address, hsr_dup_table_pkg::OFF_ENTRY_FLAGS)) begin
      readView = flagsView;
    end
    if (isAt(avs_address, hsr_dup_table_pkg::OFF_DEST_HIGH)) begin
      readView = destHighView;
    end
    if (isAt(avs_address, hsr_dup_table_pkg::OFF_DEST_LOW_SRC_HIGH)) begin
      readView = destLowSrcHighView;
    end
    if (isAt(avs_address, hsr_dup_table_pkg::OFF_SRC_LOW)) begin
      readView = srcLowView;
    end
    if (isAt(avs_address, hsr_dup_table_pkg::OFF_START_SEQ)) begin
      readView = startView;
    end
    if (isAt(avs_address, hsr_dup_table_pkg::OFF_EXPECTED_SEQ)) begin
      readView = expectedView;
    end
    if (isAt(avs_address, hsr_dup_table_pkg::OFF_OUT_OF_ORDER)) begin
      readView = outOfOrderView;
    end
  end

  // ****************************************
  // value and index registers
  // ****************************************
  always_comb begin
    logic [31:0] w;
    w = hsr_dup_table_pkg::WORD_ZERO;
    nxt_value = valueFf;
    if (wrStrobe && isAt(avs_address, hsr_dup_table_pkg::OFF_ENTRY_FLAGS))
    begin
      w = merge(flagsView, laneMask, avs_writedata,
                hsr_dup_table_pkg::FLAGS_WRITE_MASK);
      nxt_value.permanent = w[hsr_dup_table_pkg::PERM_BIT];
      nxt_value.entryAge =
        w[hsr_dup_table_pkg::AGE_MSB:hsr_dup_table_pkg::AGE_LSB];
      nxt_value.tagPath =
        w[hsr_dup_table_pkg::PATH_MSB:hsr_dup_table_pkg::PATH_LSB];
    end
    if (wrStrobe && isAt(avs_address, hsr_dup_table_pkg::OFF_DEST_HIGH)) begin
      nxt_value.destStationAddr[hsr_dup_table_pkg::ADDR_MSB:
                                hsr_dup_table_pkg::DEST_SPLIT] =
        merge(destHighView, laneMask, avs_writedata,
              hsr_dup_table_pkg::WORD_FULL);
    end
    if (wrStrobe &&
        isAt(avs_address, hsr_dup_table_pkg::OFF_DEST_LOW_SRC_HIGH)) begin
      w = merge(destLowSrcHighView, laneMask, avs_writedata,
                hsr_dup_table_pkg::WORD_FULL);
      nxt_value.destStationAddr[hsr_dup_table_pkg::DEST_SPLIT-1:0] =
        w[hsr_dup_table_pkg::HI_MSB:hsr_dup_table_pkg::HI_LSB];
      nxt_value.sourceStationAddr[hsr_dup_table_pkg::ADDR_MSB:
                                  hsr_dup_table_pkg::SRC_SPLIT] =
        w[hsr_dup_table_pkg::LO_MSB:hsr_dup_table_pkg::LO_LSB];
    end
    if (wrStrobe && isAt(avs_address, hsr_dup_table_pkg::OFF_SRC_LOW)) begin
      nxt_value.sourceStationAddr[hsr_dup_table_pkg::SRC_SPLIT-1:0] =
        merge(srcLowView, laneMask, avs_writedata,
              hsr_dup_table_pkg::WORD_FULL);
    end
    if (wrStrobe && isAt(avs_address, hsr_dup_table_pkg::OFF_START_SEQ)) begin
      {nxt_value.initialSeqnumPortA, nxt_value.initialSeqnumPortB} =
        merge(startView, laneMask, avs_writedata,
              hsr_dup_table_pkg::WORD_FULL);
    end
    if (wrStrobe && isAt(avs_address, hsr_dup_table_pkg::OFF_EXPECTED_SEQ))
    begin
      {nxt_value.awaitedSeqnumPortA, nxt_value.awaitedSeqnumPortB} =
        merge(expectedView, laneMask, avs_writedata,
              hsr_dup_table_pkg::WORD_FULL);
    end
    if (wrStrobe && isAt(avs_address, hsr_dup_table_pkg::OFF_OUT_OF_ORDER))
    begin
      {nxt_value.misorderedTotalPortA, nxt_value.misorderedTotalPortB} =
        merge(outOfOrderView, laneMask, avs_writedata,
              hsr_dup_table_pkg::WORD_FULL);
    end
  end

  // a table read in the same cycle as a bus write overrides the bus write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      valueFf <= hsr_dup_table_pkg::ENTRY_ZERO;
    end else if (stateFf == hsr_dup_table_pkg::EXEC &&
                 opFf == hsr_dup_table_pkg::ACTION_READ) begin
      valueFf <= readEntry;
    end else begin
      valueFf <= nxt_value;
    end
  end

  // upper half of the index high word is reserved and never stored
  assign indexHighNew = merge({16'h0000, indexHighFf}, laneMask,
                              avs_writedata,
                              hsr_dup_table_pkg::INDEX_HIGH_MASK);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      indexHighFf <= 16'h0000;
      indexLowFf <= hsr_dup_table_pkg::WORD_ZERO;
    end else if (wrStrobe) begin
      if (isAt(avs_address, hsr_dup_table_pkg::OFF_INDEX_HIGH)) begin
        indexHighFf <= indexHighNew[15:0];
      end
      if (isAt(avs_address, hsr_dup_table_pkg::OFF_INDEX_LOW)) begin
        indexLowFf <= merge(indexLowFf, laneMask, avs_writedata,
                            hsr_dup_table_pkg::WORD_FULL);
      end
    end
  end

  // ****************************************
  // access control
  // ****************************************
  assign ctrlNew = merge(ctrlView, laneMask, avs_writedata,
                         hsr_dup_table_pkg::CTRL_WRITE_MASK);
  assign start = wrStrobe &&
                 isAt(avs_address, hsr_dup_table_pkg::OFF_ACCESS_CTRL) &&
                 ctrlNew[hsr_dup_table_pkg::GO_BIT] && !goFf;
  assign searchEnd = stateFf == hsr_dup_table_pkg::SEARCH &&
                     scanFf == hsr_dup_table_pkg::LAST_SLOT;
  assign tallyStep = tallyFf + {13'h0000, permFf[scanFf]};

  // go is owned by hardware while set; a software zero cannot abort
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      goFf <= 1'b0;
      validFf <= 1'b0;
      searchOverFf <= 1'b0;
      directFf <= 1'b0;
      actionFf <= hsr_dup_table_pkg::ACTION_NONE;
      validCountFf <= 14'h0000;
    end else begin
      if (wrStrobe && isAt(avs_address, hsr_dup_table_pkg::OFF_ACCESS_CTRL))
      begin
        validFf <= ctrlNew[hsr_dup_table_pkg::VALID_BIT];
        directFf <= ctrlNew[hsr_dup_table_pkg::DIRECT_BIT];
        actionFf <= ctrlNew[hsr_dup_table_pkg::ACTION_MSB:
                            hsr_dup_table_pkg::ACTION_LSB];
        validCountFf <= ctrlNew[hsr_dup_table_pkg::COUNT_MSB:
                                hsr_dup_table_pkg::COUNT_LSB];
      end
      if (start) begin
        goFf <= 1'b1;
        searchOverFf <= 1'b0;
      end
      if (stateFf == hsr_dup_table_pkg::EXEC) begin
        goFf <= 1'b0;
        if (opFf == hsr_dup_table_pkg::ACTION_READ) begin
          validFf <= readEntry.permanent;
        end
      end
      if (searchEnd) begin
        goFf <= 1'b0;
        searchOverFf <= 1'b1;
        validCountFf <= tallyStep;
      end
    end
  end

  // ****************************************
  // table engine
  // ****************************************
  // hashing is a plain byte fold; collisions simply share a slot
  always_comb begin
    hashSlot = indexHighFf[15:8] ^ indexHighFf[7:0];
    for (int b = 0; b < hsr_dup_table_pkg::HASH_BYTES - 2; b++) begin
      hashSlot = hashSlot ^ indexLowFf[b*hsr_dup_table_pkg::LANE_WIDTH +:
                                       hsr_dup_table_pkg::LANE_WIDTH];
    end
  end
  assign directSlot = destHighView[hsr_dup_table_pkg::DIRECT_MSB:0];
  assign readEntry = writtenFf[slotFf] ? tableMem[slotFf] :
                     hsr_dup_table_pkg::ENTRY_ZERO;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stateFf <= hsr_dup_table_pkg::IDLE;
      opFf <= hsr_dup_table_pkg::ACTION_NONE;
      slotFf <= 8'h00;
      scanFf <= 8'h00;
      tallyFf <= 14'h0000;
    end else begin
      case (stateFf)
        hsr_dup_table_pkg::IDLE: begin
          if (start) begin
            opFf <= ctrlNew[hsr_dup_table_pkg::ACTION_MSB:
                            hsr_dup_table_pkg::ACTION_LSB];
            slotFf <= ctrlNew[hsr_dup_table_pkg::DIRECT_BIT] ?
                      directSlot : hashSlot;
            scanFf <= 8'h00;
            tallyFf <= 14'h0000;
            stateFf <= (ctrlNew[hsr_dup_table_pkg::ACTION_MSB:
                                hsr_dup_table_pkg::ACTION_LSB] ==
                        hsr_dup_table_pkg::ACTION_SEARCH) ?
                       hsr_dup_table_pkg::SEARCH :
                       hsr_dup_table_pkg::EXEC;
          end
        end
        hsr_dup_table_pkg::EXEC: begin
          stateFf <= hsr_dup_table_pkg::IDLE;
        end
        hsr_dup_table_pkg::SEARCH: begin
          tallyFf <= tallyStep;
          scanFf <= scanFf + 8'h01;
          if (searchEnd) begin
            stateFf <= hsr_dup_table_pkg::IDLE;
          end
        end
        default: begin
          stateFf <= hsr_dup_table_pkg::IDLE;
        end
      endcase
    end
  end

  // table storage has no reset; the written map hides stale contents
  always_ff @(posedge clock) begin
    if (stateFf == hsr_dup_table_pkg::EXEC &&
        opFf == hsr_dup_table_pkg::ACTION_WRITE) begin
      tableMem[slotFf] <= valueFf;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      writtenFf <= '0;
      permFf <= '0;
    end else if (stateFf == hsr_dup_table_pkg::EXEC &&
                 opFf == hsr_dup_table_pkg::ACTION_WRITE) begin
      writtenFf[slotFf] <= 1'b1;
      permFf[slotFf] <= valueFf.permanent;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_bus_one_wait: assert property (
    (avs_read | avs_write) && !ackFf |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  chk_perm_read: assert property (
    ackFf && avs_read && isAt(avs_address, hsr_dup_table_pkg::OFF_ENTRY_FLAGS)
    |-> avs_readdata[hsr_dup_table_pkg::PERM_BIT] == $past(valueFf.permanent)
        && (avs_readdata & ~hsr_dup_table_pkg::FLAGS_WRITE_MASK) == 32'h0)
    else $error("flags word wrong or reserved bits set");
  chk_dest_high: assert property (
    ackFf && avs_read && isAt(avs_address, hsr_dup_table_pkg::OFF_DEST_HIGH)
    |-> avs_readdata == $past(destHighView))
    else $error("destination high word mismatch");
  chk_seq_halves: assert property (
    ackFf && avs_read && isAt(avs_address, hsr_dup_table_pkg::OFF_START_SEQ)
    |-> avs_readdata[hsr_dup_table_pkg::HI_MSB:hsr_dup_table_pkg::HI_LSB]
        == $past(valueFf.initialSeqnumPortA))
    else $error("start sequence halves swapped");
  chk_direct_slot: assert property (
    start && ctrlNew[hsr_dup_table_pkg::DIRECT_BIT]
    |=> slotFf == $past(directSlot))
    else $error("direct slot not taken from value word");
  chk_op_decode: assert property (
    start |=> opFf == $past(ctrlNew[hsr_dup_table_pkg::ACTION_MSB:
                                    hsr_dup_table_pkg::ACTION_LSB]) &&
      (stateFf == hsr_dup_table_pkg::SEARCH) ==
      (opFf == hsr_dup_table_pkg::ACTION_SEARCH))
    else $error("operation decode wrong");
  chk_go_clears: assert property (
    $rose(goFf) && stateFf == hsr_dup_table_pkg::EXEC |=> !goFf)
    else $error("go not cleared after single operation");
  chk_search_len: assert property (
    $rose(goFf) && stateFf == hsr_dup_table_pkg::SEARCH
    |-> ##255 goFf ##1 !goFf)
    else $error("search length wrong");
  chk_search_count: assert property (
    $rose(searchOverFf) |-> validCountFf == 14'($countones(permFf)))
    else $error("valid count wrong after search");
  chk_read_loads: assert property (
    stateFf == hsr_dup_table_pkg::EXEC &&
    opFf == hsr_dup_table_pkg::ACTION_READ |=> valueFf == $past(readEntry))
    else $error("table read did not load value registers");

  cov_write_op: cover property (stateFf == hsr_dup_table_pkg::EXEC &&
                                opFf == hsr_dup_table_pkg::ACTION_WRITE);
  cov_read_op: cover property (stateFf == hsr_dup_table_pkg::EXEC &&
                               opFf == hsr_dup_table_pkg::ACTION_READ);
  cov_search_end: cover property ($rose(searchOverFf));

endmodule
`default_nettype wire

// ===== sim/test_hsr_duplicate_table_data_regs.sv
`timescale 1ns/10ps
`default_nettype none
module test_hsr_duplicate_table_data_regs;
  // ********************
  // stimulus and model
  // ********************
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [11:0] avsAddress = 12'h000;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h00000000;
  logic [3:0] avsByteenable = 4'hF;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  int errCount = 0;
  int comparisons = 0;
  integer seed = 32'h4e24f8cc;
  logic [31:0] val [7];
  logic [31:0] tbl [256][7];
  logic [31:0] q;
  logic firstGo;

  always #5 clock = ~clock;

  hsr_duplicate_table_data_regs hsr_duplicate_table_data_regs_inst (
    .clock(clock), .rst(rst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest));

  // ********************
  // tasks
  // ********************
  task end_of_test;
    $display("errors %0d comparisons %0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errCount++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // request holds until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= d;
    avsByteenable <= be;
    do begin
      @(posedge clock);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (n >= 50) begin
      errCount++;
      end_of_test();
    end
  endtask

  task wv(input int i, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, hsr_dup_table_pkg::OFF_ENTRY_FLAGS + 12'(4 * i), d, be);
    for (int b = 0; b < 4; b++)
      if (be[b]) val[i][8*b+:8] = d[8*b+:8];
    if (i == 0) val[0] &= 32'h9C00000F;
  endtask

  task rv(input int i);
    bus(1'b0, hsr_dup_table_pkg::OFF_ENTRY_FLAGS + 12'(4 * i), 32'h0, 4'hF);
    chk(q, val[i]);
  endtask

  // polls go until the device clears it; bounded so a stuck go ends the run
  task op(input logic [31:0] c);
    int n;
    n = 0;
    bus(1'b1, hsr_dup_table_pkg::OFF_ACCESS_CTRL, c, 4'hF);
    do begin
      bus(1'b0, hsr_dup_table_pkg::OFF_ACCESS_CTRL, 32'h0, 4'hF);
      if (n == 0) firstGo = q[7];
      n++;
    end while (q[7] !== 1'b0 && n < 200);
    if (n >= 200) begin
      errCount++;
      end_of_test();
    end
  endtask

  initial begin
    int s;
    int cnt;
    logic [31:0] d;
    logic [15:0] ih;
    foreach (val[i]) val[i] = 32'h0;
    foreach (tbl[a, b]) tbl[a][b] = 32'h0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rv(i);
      wv(i, $random(seed), 4'hF);
      rv(i);
    end
    wv(0, 32'hFFFFFFFF, 4'h9);
    rv(0);
    bus(1'b0, 12'h470, 32'h0, 4'hF);
    chk(q, 32'h0);
    for (int k = 0; k < 8; k++) begin
      d = $random(seed);
      bus(1'b1, hsr_dup_table_pkg::OFF_INDEX_HIGH, d, 4'hF);
      ih = d[15:0];
      d = $random(seed);
      bus(1'b1, hsr_dup_table_pkg::OFF_INDEX_LOW, d, 4'hF);
      // odd passes go through the hashed index registers, even ones direct
      if (k[0])
        s = ih[15:8] ^ ih[7:0] ^ d[31:24] ^ d[23:16] ^ d[15:8] ^ d[7:0];
      else
        s = $random(seed) & 255;
      for (int i = 0; i < 7; i++) wv(i, $random(seed), 4'hF);
      d = val[1];
      d[7:0] = 8'(s);
      wv(1, d, 4'hF);
      op(k[0] ? 32'h00000081 : 32'h00000085);
      for (int i = 0; i < 7; i++) tbl[s][i] = val[i];
      for (int i = 0; i < 7; i++) wv(i, 32'h0, 4'hF);
      wv(1, {24'h0, 8'(s)}, 4'hF);
      op(k[0] ? 32'h00000082 : 32'h00000086);
      chk({31'h0, firstGo}, 32'h0);
      chk({31'h0, q[6]}, {31'h0, tbl[s][0][31]});
      for (int i = 0; i < 7; i++) begin
        val[i] = tbl[s][i];
        rv(i);
      end
      op(32'h00000084);
      rv(2);
    end
    cnt = 0;
    for (int a = 0; a < 256; a++) cnt += tbl[a][0][31];
    op(32'h00000083);
    chk({31'h0, firstGo}, 32'h1);
    chk({18'h0, q[29:16]}, 32'(cnt));
    chk({31'h0, q[5]}, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
